// >>> rtl/port1_port2_function_select.v
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
// Function
// - port1 bit5 code: ext irq, q lower out3, q event in, 11 illegal
// - port1 bit4 code: ext irq, q lower out2, q capture in, 11 illegal
// - port1 bit3 code: ext irq, q upper out3, q irq in3, q out3
// - port1 bit2 code: ext irq, q upper out2, q irq in2, q out2
// - port1 bit1 code: ext irq, q upper out1, q irq in1, q out1
// - port1 bit0 code: ext irq, q lower out1, q irq in0, q out0
// - port two bits individually in or out; bit0 input only
// - port two bit0 always feeds the non-maskable interrupt
// - reading port two data bit0 returns the nmi pin level
// - test reset high overrides bits 6,7 settings with test data pins
// - port2 mode ctrl 8 bits, reset 01, bit0 one, bit3 zero
// - port two bit6 is test data in, bit7 test data out
// - port two bit6/bit4 select ext irq or timer c out2/out0
// - port two bit5 code: ext irq, c out1, ud updown in, ud out
// - port two bit2 code: ext irq, p out1_1, p irq in1_1, illegal
// - port two bit1 code: ext irq, p out1_0, p capture inputs, illegal
`include "pin_select_regs.vh"

module port1_port2_function_select
(
    input  wire        mclk_in,
    input  wire        srst_in,
    // register port
    input  wire [31:0] addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [7:0]  rdata_out,
    // port one pins
    input  wire [7:0]  port1_pin_in,
    output reg  [7:0]  port1_pin_out,
    output reg  [7:0]  port1_pin_oe_out,
    // port two pins
    input  wire [7:0]  port2_pin_in,
    output reg  [7:0]  port2_pin_out,
    output reg  [7:0]  port2_pin_oe_out,
    input  wire        test_reset_in,
    // timer q
    input  wire        timer_q_lower_out1_in,
    input  wire        timer_q_lower_out2_in,
    input  wire        timer_q_lower_out3_in,
    input  wire        timer_q_upper_out1_in,
    input  wire        timer_q_upper_out2_in,
    input  wire        timer_q_upper_out3_in,
    input  wire [3:0]  timer_q_out_in,
    output reg  [3:0]  timer_q_irq_out,
    output reg         timer_q_event_out,
    output reg         timer_q_capture_out,
    // timer c, ud, p
    input  wire [3:0]  timer_c_out_in,
    input  wire        timer_ud_out_in,
    output reg         timer_ud_updown_out,
    input  wire        timer_p_out1_0_in,
    input  wire        timer_p_out1_1_in,
    output reg         timer_p_capture_out,
    output reg         timer_p_irq_in1_1_out,
    // interrupt and debug
    output reg  [7:0]  port1_ext_irq_out,
    output reg  [7:0]  port2_ext_irq_out,
    output reg         nmi_out,
    input  wire        test_data_out_in,
    output reg         test_data_in_out
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [7:0] port1_data;
reg  [7:0] port1_direction;
reg  [7:0] port1_mode_ctrl;
reg  [7:0] port1_func_ext;
reg  [7:0] port1_func;
reg  [7:0] port_two_data;
reg  [7:0] port_two_direction;
reg  [7:0] port2_mode_ctrl;
reg  [7:0] port2_func_ext;
reg  [7:0] port2_func;
reg  [7:0] next_rdata;
wire [7:0] p1_sync;
wire [7:0] p2_sync;
wire [1:0] trst_sync;

pin_sync #(.WIDTH(8)) u_sync1
(
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in (port1_pin_in),
    .sync_out (p1_sync)
);

pin_sync #(.WIDTH(8)) u_sync2
(
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in (port2_pin_in),
    .sync_out (p2_sync)
);

pin_sync #(.WIDTH(2)) u_sync3
(
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in ({test_reset_in, test_data_out_in}),
    .sync_out (trst_sync)
);

always @(posedge mclk_in)
begin
    if (srst_in)
    begin
        port1_data         <= `RST_DATA;
        port1_direction    <= `RST_DIRECTION;
        port1_mode_ctrl    <= `RST_PORT1_MODE_CTRL;
        port1_func_ext     <= `RST_FUNC;
        port1_func         <= `RST_FUNC;
        port_two_data      <= `RST_DATA;
        port_two_direction <= `RST_DIRECTION;
        port2_mode_ctrl    <= `RST_PORT2_MODE_CTRL;
        port2_func_ext     <= `RST_FUNC;
        port2_func         <= `RST_FUNC;
    end
    else if (wr_in)
    begin
        case (addr_in)
            `ADDR_PORT1_DATA:      port1_data <= wdata_in;
            `ADDR_PORT1_DIRECTION: port1_direction <= wdata_in;
            `ADDR_PORT1_MODE_CTRL:
                port1_mode_ctrl <= wdata_in & `PORT1_MODE_MASK;
            `ADDR_PORT1_FUNC_EXT:
                port1_func_ext <= wdata_in & `PORT1_FUNC_MASK;
            `ADDR_PORT1_FUNC:
                port1_func <= wdata_in & `PORT1_FUNC_MASK;
            `ADDR_PORT_TWO_DATA:   port_two_data <= wdata_in;
            `ADDR_PORT_TWO_DIR:
                port_two_direction <= wdata_in | 8'h01;
            `ADDR_PORT2_MODE_CTRL:
                port2_mode_ctrl <= (wdata_in & `PORT2_MODE_MASK)
                                   | `PORT2_MODE_FIXED_ONE;
            `ADDR_PORT2_FUNC_EXT:
                port2_func_ext <= wdata_in & `PORT2_FUNC_EXT_MASK;
            `ADDR_PORT2_FUNC:
                port2_func <= wdata_in & `PORT2_FUNC_MASK;
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// read back
// ----------------------------------------------------------------
always @*
begin
    case (addr_in)
        // port mode pins read the sampled level when input
        `ADDR_PORT1_DATA:
            next_rdata = (port1_data & ~port1_direction)
                         | (p1_sync & port1_direction);
        `ADDR_PORT1_DIRECTION: next_rdata = port1_direction;
        `ADDR_PORT1_MODE_CTRL: next_rdata = port1_mode_ctrl;
        `ADDR_PORT1_FUNC_EXT:  next_rdata = port1_func_ext;
        `ADDR_PORT1_FUNC:      next_rdata = port1_func;
        `ADDR_PORT_TWO_DATA:
            next_rdata = (port_two_data & ~port_two_direction)
                         | (p2_sync & port_two_direction);
        `ADDR_PORT_TWO_DIR:    next_rdata = port_two_direction;
        `ADDR_PORT2_MODE_CTRL: next_rdata = port2_mode_ctrl;
        `ADDR_PORT2_FUNC_EXT:  next_rdata = port2_func_ext;
        `ADDR_PORT2_FUNC:      next_rdata = port2_func;
        default:               next_rdata = 8'h00;
    endcase
end

always @(posedge mclk_in)
begin
    if (srst_in)
        rdata_out <= 8'h00;
    else if (rd_in)
        rdata_out <= next_rdata;
    else
        rdata_out <= 8'h00;
end

// ----------------------------------------------------------------
// port one pin muxing
// ----------------------------------------------------------------
reg [7:0] next_p1_out;
reg [7:0] next_p1_oe;
reg [7:0] next_p1_irq;
reg [3:0] next_q_irq;
reg       next_q_event;
reg       next_q_capture;
reg [1:0] code1;
reg       alt_out;
integer   i;

always @*
begin
    next_p1_out    = 8'h00;
    next_p1_oe     = 8'h00;
    next_p1_irq    = 8'h00;
    next_q_irq     = 4'h0;
    next_q_event   = 1'b0;
    next_q_capture = 1'b0;
    code1          = 2'h0;
    alt_out        = 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
        code1   = {port1_func_ext[i], port1_func[i]};
        alt_out = 1'b0;
        if (!port1_mode_ctrl[i] || i > 5)
        begin
            next_p1_out[i] = port1_data[i];
            next_p1_oe[i]  = ~port1_direction[i];
        end
        else
        begin
            case (code1)
                `SEL_EXT_IRQ: next_p1_irq[i] = p1_sync[i];
                `SEL_ALT_A:
                begin
                    case (i)
                        0: alt_out = timer_q_lower_out1_in;
                        1: alt_out = timer_q_upper_out1_in;
                        2: alt_out = timer_q_upper_out2_in;
                        3: alt_out = timer_q_upper_out3_in;
                        4: alt_out = timer_q_lower_out2_in;
                        default: alt_out = timer_q_lower_out3_in;
                    endcase
                    next_p1_out[i] = alt_out;
                    next_p1_oe[i]  = 1'b1;
                end
                `SEL_ALT_B:
                begin
                    if (i == 5)
                        next_q_event = p1_sync[i];
                    else if (i == 4)
                        next_q_capture = p1_sync[i];
                    else
                        next_q_irq[i] = p1_sync[i];
                end
                default:
                begin
                    // code 11 on bits 4,5 leaves the pin undriven
                    if (i < 4)
                    begin
                        next_p1_out[i] = timer_q_out_in[i];
                        next_p1_oe[i]  = 1'b1;
                    end
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------
// port two pin muxing
// ----------------------------------------------------------------
reg [7:0] next_p2_out;
reg [7:0] next_p2_oe;
reg [7:0] next_p2_irq;
reg       next_ud;
reg       next_p_cap;
reg       next_p_irq;
reg       next_tdi;
reg [1:0] code2;
integer   j;

always @*
begin
    next_p2_out = 8'h00;
    next_p2_oe  = 8'h00;
    next_p2_irq = 8'h00;
    next_ud     = 1'b0;
    next_p_cap  = 1'b0;
    next_p_irq  = 1'b0;
    next_tdi    = 1'b0;
    code2       = 2'h0;
    for (j = 1; j < 8; j = j + 1)
    begin
        code2 = {port2_func_ext[j], port2_func[j]};
        if (!port2_mode_ctrl[j])
        begin
            next_p2_out[j] = port_two_data[j];
            next_p2_oe[j]  = ~port_two_direction[j];
        end
        else if (j == 7)
        begin
            next_p2_out[j] = timer_c_out_in[3];
            next_p2_oe[j]  = 1'b1;
        end
        else if (j == 6 || j == 4)
        begin
            if (port2_func[j])
            begin
                next_p2_out[j] = timer_c_out_in[j-4];
                next_p2_oe[j]  = 1'b1;
            end
            else
                next_p2_irq[j] = p2_sync[j];
        end
        else
        begin
            case (code2)
                `SEL_EXT_IRQ: next_p2_irq[j] = p2_sync[j];
                `SEL_ALT_A:
                begin
                    next_p2_oe[j] = 1'b1;
                    if (j == 5)
                        next_p2_out[j] = timer_c_out_in[1];
                    else if (j == 2)
                        next_p2_out[j] = timer_p_out1_1_in;
                    else
                        next_p2_out[j] = timer_p_out1_0_in;
                end
                `SEL_ALT_B:
                begin
                    if (j == 5)
                        next_ud = p2_sync[j];
                    else if (j == 2)
                        next_p_irq = p2_sync[j];
                    else
                        next_p_cap = p2_sync[j];
                end
                default:
                begin
                    if (j == 5)
                    begin
                        next_p2_out[j] = timer_ud_out_in;
                        next_p2_oe[j]  = 1'b1;
                    end
                end
            endcase
        end
    end
    // debug pins take over bits 6 and 7
    if (trst_sync[1])
    begin
        next_p2_irq[`BIT_TEST_DATA_IN]  = 1'b0;
        next_p2_oe[`BIT_TEST_DATA_IN]   = 1'b0;
        next_p2_out[`BIT_TEST_DATA_IN]  = 1'b0;
        next_tdi = p2_sync[`BIT_TEST_DATA_IN];
        next_p2_out[`BIT_TEST_DATA_OUT] = trst_sync[0];
        next_p2_oe[`BIT_TEST_DATA_OUT]  = 1'b1;
        next_p2_irq[`BIT_TEST_DATA_OUT] = 1'b0;
    end
end

// ----------------------------------------------------------------
// output flops
// ----------------------------------------------------------------
always @(posedge mclk_in)
begin
    if (srst_in)
    begin
        port1_pin_out         <= 8'h00;
        port1_pin_oe_out      <= 8'h00;
        port2_pin_out         <= 8'h00;
        port2_pin_oe_out      <= 8'h00;
        port1_ext_irq_out     <= 8'h00;
        port2_ext_irq_out     <= 8'h00;
        timer_q_irq_out       <= 4'h0;
        timer_q_event_out     <= 1'b0;
        timer_q_capture_out   <= 1'b0;
        timer_ud_updown_out   <= 1'b0;
        timer_p_capture_out   <= 1'b0;
        timer_p_irq_in1_1_out <= 1'b0;
        nmi_out               <= 1'b0;
        test_data_in_out      <= 1'b0;
    end
    else
    begin
        port1_pin_out         <= next_p1_out;
        port1_pin_oe_out      <= next_p1_oe;
        port2_pin_out         <= next_p2_out;
        port2_pin_oe_out      <= next_p2_oe & 8'hfe;
        port1_ext_irq_out     <= next_p1_irq;
        port2_ext_irq_out     <= next_p2_irq;
        timer_q_irq_out       <= next_q_irq;
        timer_q_event_out     <= next_q_event;
        timer_q_capture_out   <= next_q_capture;
        timer_ud_updown_out   <= next_ud;
        timer_p_capture_out   <= next_p_cap;
        timer_p_irq_in1_1_out <= next_p_irq;
        nmi_out               <= p2_sync[`BIT_NMI];
        test_data_in_out      <= next_tdi;
    end
end

endmodule

// >>> pkg/pin_select_regs.vh
`ifndef PIN_SELECT_REGS_VH
`define PIN_SELECT_REGS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_PORT1_DATA       32'hfffff402
`define ADDR_PORT1_DIRECTION  32'hfffff422
`define ADDR_PORT1_MODE_CTRL  32'hfffff442
`define ADDR_PORT1_FUNC_EXT   32'hfffff702
`define ADDR_PORT1_FUNC       32'hfffff462
`define ADDR_PORT_TWO_DATA    32'hfffff404
`define ADDR_PORT_TWO_DIR     32'hfffff424
`define ADDR_PORT2_MODE_CTRL  32'hfffff444
`define ADDR_PORT2_FUNC_EXT   32'hfffff704
`define ADDR_PORT2_FUNC       32'hfffff464

// ----------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------
`define RST_DATA              8'h00
`define RST_DIRECTION         8'hff
`define RST_PORT1_MODE_CTRL   8'h00
`define RST_PORT2_MODE_CTRL   8'h01
`define RST_FUNC              8'h00
`define PORT1_MODE_MASK       8'h3f
`define PORT2_MODE_FIXED_ONE  8'h01
`define PORT2_MODE_FIXED_ZERO 8'h08
`define PORT2_MODE_MASK       8'hf6
`define PORT2_FUNC_MASK       8'h76
`define PORT2_FUNC_EXT_MASK   8'h26
`define PORT1_FUNC_MASK       8'h3f

// ----------------------------------------------------------------
// select codes
// ----------------------------------------------------------------
`define SEL_EXT_IRQ           2'h0
`define SEL_ALT_A             2'h1
`define SEL_ALT_B             2'h2
`define SEL_ALT_C             2'h3

// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define BIT_NMI               0
`define BIT_TEST_DATA_IN      6
`define BIT_TEST_DATA_OUT     7

`endif

// >>> rtl/pin_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two flip-flop synchroniser for a group of pins
// ----------------------------------------------------------------
module pin_sync
#(
    parameter WIDTH = 8
)
(
    input  wire             mclk_in,
    input  wire             srst_in,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

always @(posedge mclk_in)
begin
    if (srst_in)
    begin
        meta     <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
        meta     <= async_in;
        sync_out <= meta;
    end
end

endmodule

// >>> verification/pin_select_checker_assertions.sv
`timescale 1ns/1ps
`include "pin_select_regs.vh"

// ------
// port checker
// ------
module pin_select_checker
(
    input wire logic        mclk_in,
    input wire logic        srst_in,
    input wire logic [31:0] addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic [7:0]  port1_pin_oe_out,
    input wire logic [7:0]  port1_ext_irq_out,
    input wire logic [3:0]  timer_q_irq_out,
    input wire logic [7:0]  port2_pin_in,
    input wire logic [7:0]  port2_pin_out,
    input wire logic [7:0]  port2_pin_oe_out,
    input wire logic        test_reset_in,
    input wire logic        test_data_out_in,
    input wire logic        test_data_in_out,
    input wire logic        nmi_out
);
    logic [2:0] up_cnt;
    logic [7:0] p1_dir;
    logic [7:0] p1_mode;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // shadow of the port one settings seen on the bus
    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            up_cnt  <= 3'h0;
            p1_dir  <= 8'hff;
            p1_mode <= 8'h00;
        end
        else
        begin
            if (up_cnt != 3'h7)
                up_cnt <= up_cnt + 3'h1;
            if (wr_in && addr_in == `ADDR_PORT1_DIRECTION)
                p1_dir <= wdata_in;
            if (wr_in && addr_in == `ADDR_PORT1_MODE_CTRL)
                p1_mode <= wdata_in & `PORT1_MODE_MASK;
        end
    end

    nmi_pin_idle_a:
    assert property (port2_pin_oe_out[0] == 1'b0)
        else $error("nmi pin driven");
    nmi_follow_a:
    assert property (up_cnt == 3'h7 |-> nmi_out == $past(port2_pin_in[0], 3))
        else $error("nmi does not follow pin");
    nmi_read_a:
    assert property (rd_in && addr_in == `ADDR_PORT_TWO_DATA
                     |=> rdata_out[0] == nmi_out)
        else $error("data bit0 differs from nmi level");
    mode_fixed_a:
    assert property (rd_in && addr_in == `ADDR_PORT2_MODE_CTRL
                     |=> rdata_out[0] && !rdata_out[3])
        else $error("mode fixed bits wrong");
    test_pins_a:
    assert property (test_reset_in [*4] |-> port2_pin_oe_out[7:6] == 2'b10)
        else $error("test pins not taken over");
    test_dout_a:
    assert property (test_reset_in [*6]
                     |-> port2_pin_out[7] == $past(test_data_out_in, 3))
        else $error("test data out not on pin");
    test_din_a:
    assert property (test_reset_in [*6]
                     |-> test_data_in_out == $past(port2_pin_in[6], 3))
        else $error("test data in not from pin");
    port_drive_a:
    assert property (up_cnt == 3'h7 |-> ((port1_pin_oe_out ^ ~$past(p1_dir))
                     & ~$past(p1_mode) & ~p1_mode) == 8'h00)
        else $error("port mode enable differs from direction");
    irq_drive_a:
    assert property (((port1_ext_irq_out | {4'h0, timer_q_irq_out})
                     & port1_pin_oe_out) == 8'h00)
        else $error("input function on a driven pin");

    cover property (test_reset_in [*6]);
    cover property (rd_in && addr_in == `ADDR_PORT_TWO_DATA);
    cover property (timer_q_irq_out != 4'h0);
endmodule

bind port1_port2_function_select pin_select_checker chk_u
(
    .mclk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .port1_pin_oe_out, .port1_ext_irq_out, .timer_q_irq_out, .port2_pin_in,
    .port2_pin_out, .port2_pin_oe_out, .test_reset_in, .test_data_out_in,
    .test_data_in_out, .nmi_out
);

// >>> verification/board_side.sv
`timescale 1ns/1ps

// ------
// board pins and debug probe
// ------
module board_side
(
    input  wire logic [7:0] p1_lvl_in,
    input  wire logic [7:0] p2_lvl_in,
    input  wire logic [7:0] p1_out_in,
    input  wire logic [7:0] p1_oe_in,
    input  wire logic [7:0] p2_out_in,
    input  wire logic [7:0] p2_oe_in,
    input  wire logic       dbg_req_in,
    output wire logic [7:0] p1_wire_out,
    output wire logic [7:0] p2_wire_out,
    output wire logic       test_reset_out
);
    // a driven pin shows the chip level, a free pin the board level
    assign p1_wire_out = (p1_oe_in & p1_out_in) | (~p1_oe_in & p1_lvl_in);
    assign p2_wire_out = (p2_oe_in & p2_out_in) | (~p2_oe_in & p2_lvl_in);
    // test reset low unless the probe asks for it
    assign test_reset_out = dbg_req_in;
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
`include "pin_select_regs.vh"

module tb;
    logic        mclk_in, srst_in, wr_in, rd_in, rd_prev, dbg, trst;
    logic        ud, p0, p1, tdo, tdi, cap, pirq, upd, evt, qcap, nmi;
    logic [31:0] addr_in, seed;
    logic [7:0]  wdata_in, rdata_out, lvl1, lvl2, w1, w2, o1, oe1, o2, oe2;
    logic [7:0]  x1, x2, d, r, eoe, eout, eirq;
    logic [2:0]  q_lo, q_up;
    logic [3:0]  q_out, c_out, q_irq;
    logic [7:0]  exp_q[$];
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          c;

    port1_port2_function_select dut_u
    (
        .mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .port1_pin_in(w1), .port1_pin_out(o1),
        .port1_pin_oe_out(oe1), .port2_pin_in(w2), .port2_pin_out(o2),
        .port2_pin_oe_out(oe2), .test_reset_in(trst),
        .timer_q_lower_out1_in(q_lo[0]), .timer_q_lower_out2_in(q_lo[1]),
        .timer_q_lower_out3_in(q_lo[2]), .timer_q_upper_out1_in(q_up[0]),
        .timer_q_upper_out2_in(q_up[1]), .timer_q_upper_out3_in(q_up[2]),
        .timer_q_out_in(q_out), .timer_q_irq_out(q_irq),
        .timer_q_event_out(evt), .timer_q_capture_out(qcap),
        .timer_c_out_in(c_out), .timer_ud_out_in(ud),
        .timer_ud_updown_out(upd), .timer_p_out1_0_in(p0),
        .timer_p_out1_1_in(p1), .timer_p_capture_out(cap),
        .timer_p_irq_in1_1_out(pirq), .port1_ext_irq_out(x1),
        .port2_ext_irq_out(x2), .nmi_out(nmi), .test_data_out_in(tdo),
        .test_data_in_out(tdi)
    );

    board_side far_u
    (
        .p1_lvl_in(lvl1), .p2_lvl_in(lvl2), .p1_out_in(o1), .p1_oe_in(oe1),
        .p2_out_in(o2), .p2_oe_in(oe2), .dbg_req_in(dbg),
        .p1_wire_out(w1), .p2_wire_out(w2), .test_reset_out(trst)
    );

    // ------
    // helpers
    // ------
    function logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [31:0] a, input logic [7:0] v);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task rd(input logic [31:0] a, input logic [7:0] v);
        addr_in <= a;
        rd_in   <= 1'b1;
        exp_q.push_back(v);
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task code(input logic [31:0] ae, input logic [31:0] af,
              input logic [7:0] e, input logic [7:0] f);
        wr(af, 8'h00);
        wr(ae, e);
        wr(af, f);
    endtask

    task shake();
        seed = nxt(seed);
        {lvl2, lvl1} <= seed[15:0];
        {tdo, ud, c_out, q_out, q_up, q_lo} <= seed[31:16];
        seed = nxt(seed);
        {p1, p0} <= seed[1:0];
        repeat (4) @(posedge mclk_in);
    endtask

    task tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------
    // clock, read monitor, timeout
    // ------
    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in)
    begin
        rd_prev <= rd_in;
        if (rd_prev)
            chk(rdata_out, exp_q.pop_front());
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ------
    // main sequence
    // ------
    initial
    begin
        {srst_in, dbg, wr_in, rd_in} = 4'h8;
        {addr_in, wdata_in} = 40'h0;
        seed = 32'h92e9986d;
        {lvl1, lvl2, tdo, ud, c_out, q_out, q_up, q_lo, p1, p0} = '0;
        repeat (10) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        rd(`ADDR_PORT2_MODE_CTRL, 8'h01);
        rd(`ADDR_PORT1_DIRECTION, 8'hff);
        rd(32'hfffff500, 8'h00);
        wr(`ADDR_PORT2_MODE_CTRL, 8'hff);
        rd(`ADDR_PORT2_MODE_CTRL, 8'hf7);
        wr(`ADDR_PORT1_MODE_CTRL, 8'h3f);
        for (c = 0; c < 4; c++)
        begin
            eoe = (c == 3) ? 8'h0f : 8'h3f;
            code(`ADDR_PORT1_FUNC_EXT, `ADDR_PORT1_FUNC,
                 c[1] ? eoe : 8'h00, c[0] ? eoe : 8'h00);
            shake();
            eoe  = (c == 1) ? 8'h3f : (c == 3) ? 8'h0f : 8'h00;
            eout = (c == 1) ? {2'b00, q_lo[2:1], q_up, q_lo[0]} : q_out;
            chk(oe1, eoe);
            chk(o1 & eoe, eout & eoe);
            eirq = (c == 0) ? 8'h3f : (c == 3) ? 8'h30 : 8'h00;
            chk(x1 & 8'h3f, lvl1 & eirq);
            chk({2'b00, evt, qcap, q_irq},
                (c == 2) ? lvl1 & 8'h3f : 8'h00);
        end
        wr(`ADDR_PORT1_MODE_CTRL, 8'h00);
        wr(`ADDR_PORT2_MODE_CTRL, 8'h00);
        seed = nxt(seed);
        {d, r} = seed[15:0];
        wr(`ADDR_PORT1_DIRECTION, r);
        wr(`ADDR_PORT_TWO_DIR, r);
        wr(`ADDR_PORT1_DATA, d);
        wr(`ADDR_PORT_TWO_DATA, d);
        shake();
        chk(oe1, ~r);
        chk(o1 & ~r, d & ~r);
        chk(oe2, ~r & 8'hfe);
        chk({7'h0, nmi}, {7'h0, lvl2[0]});
        rd(`ADDR_PORT1_DATA, (d & ~r) | (lvl1 & r));
        rd(`ADDR_PORT_TWO_DATA, (d & ~r & 8'hfe) | (lvl2 & (r | 1)));
        wr(`ADDR_PORT_TWO_DIR, 8'hff);
        wr(`ADDR_PORT2_MODE_CTRL, 8'hf6);
        for (c = 0; c < 4; c++)
        begin
            code(`ADDR_PORT2_FUNC_EXT, `ADDR_PORT2_FUNC,
                 (c == 3) ? 8'h20 : {8{c[1]}}, {8{c[0]}});
            shake();
            eoe  = c[0] ? 8'hf6 : 8'h80;
            eout = {c_out[3:2], (c == 3) ? ud : c_out[1], c_out[0], 1'b0,
                    p1, p0, 1'b0};
            eirq = (c == 0) ? 8'h76 : (c == 2) ? 8'h50 : 8'h00;
            chk(oe2, eoe);
            chk(o2 & eoe, eout & eoe);
            chk(x2 & 8'h76, lvl2 & eirq);
            chk({5'h0, cap, pirq, upd},
                (c == 2) ? {5'h0, lvl2[1], lvl2[2], lvl2[5]} : 8'h00);
        end
        dbg <= 1'b1;
        shake();
        repeat (3) @(posedge mclk_in);
        chk(oe2, 8'hb6);
        chk({7'h0, o2[7]}, {7'h0, tdo});
        chk({7'h0, tdi}, {7'h0, lvl2[6]});
        dbg <= 1'b0;
        shake();
        chk(oe2, 8'hf6);
        tally_and_finish();
    end
endmodule
